// file: dv/ccr_far_model.sv
// Far-side model: the local I2C host driving the SCL and SDA pins.
// Assumes the bench pulses go for one frame; both pins idle high on pull-ups.
`timescale 1ns/1ns
module ccr_far_model (
    input wire logic go,
    input wire logic glitch,
    output logic scl,
    output logic sda
);
    // ==========================================================
    // Frames of nine 800 ns SCL periods; SCL stands high between frames
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    always @(posedge go)
    begin
        // Odd offset keeps the pins out of phase with the system clock
        #37;
        for (int i = 0; i < 9; i++)
        begin
            scl = 1'b0;
            #200 sda = i[0];
            #200 scl = 1'b1;
            #400;
        end
        sda = 1'b1;
    end
    // One 100 ns low pulse, shorter than the filter accepts
    always @(posedge glitch)
    begin
        scl = 1'b0;
        #100 scl = 1'b1;
    end
endmodule

// file: dv/ccr_regs_tb_top.sv
// Self-checking bench for the control-channel config registers.
// Assumes ccr_pkg and ccr_regs are compiled first; bench inputs change 10 ns after a rising edge, far-model frame pins 47 ns after.
`timescale 1ns/1ns
module ccr_regs_tb_top;
    import ccr_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    ccr_reg_req_type reg_req = '0;
    ccr_id_req_type id_req = '0;
    ccr_i2s_mode_type detect_mode = I2S_2CH;
    logic low_freq_mode = 1'b0, master_en = 1'b0, stretch_req = 1'b0, repeater_mode = 1'b0;
    logic detect_valid = 1'b0, bist_start = 1'b0, bist_active = 1'b0, crc_err = 1'b0;
    logic crc_clear_cmd = 1'b0, go = 1'b0, glitch = 1'b0;
    logic scl_in, sda_in, forward_valid, forward_bidir_control_channel, scl_filt, sda_held;
    logic scl_out, scl_oe, stretch_release, surround_en, data_island_en;
    logic [7:0] reg_rdata;
    int err_count = 0;
    int tests_run = 0;
    int n;

    always #50 clock = ~clock;

    ccr_far_model i_ccr_far_model (.go(go), .glitch(glitch), .scl(scl_in), .sda(sda_in));

    ccr_regs i_ccr_regs (
        .clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata), .id_req(id_req),
        .local_id(7'h12), .remote_des_id(7'h2C), .remote_slave_id(7'h50),
        .forward_valid(forward_valid),
        .forward_bidir_control_channel(forward_bidir_control_channel),
        .scl_in(scl_in), .sda_in(sda_in), .scl_filt(scl_filt), .sda_held(sda_held),
        .low_freq_mode(low_freq_mode), .master_en(master_en), .scl_out(scl_out),
        .scl_oe(scl_oe), .stretch_req(stretch_req), .stretch_release(stretch_release),
        .repeater_mode(repeater_mode), .detect_valid(detect_valid), .detect_mode(detect_mode),
        .surround_en(surround_en), .data_island_en(data_island_en), .bist_start(bist_start),
        .bist_active(bist_active), .crc_err(crc_err), .crc_clear_cmd(crc_clear_cmd)
    );

    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // A wait that uses up its bound ends the run as a failure
    task automatic bound(input int k, input int max);
        if (k >= max)
        begin
            err_count++;
            close_out;
        end
    endtask
    task automatic step;
        @(posedge clock);
        #10;
    endtask
    // Each access takes two cycles so a driver never assigns twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{1'b1, 1'b0, a, d};
        step;
        reg_req = '0;
        step;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        step;
        reg_req = '0;
        chk(reg_rdata, exp);
        step;
    endtask
    task automatic fw(input logic [6:0] t, input logic e);
        id_req = '{1'b1, t};
        step;
        id_req = '0;
        chk({7'h00, forward_valid}, 8'h01);
        chk({7'h00, forward_bidir_control_channel}, {7'h00, e});
        step;
    endtask
    task automatic stretch(input logic [7:0] exp);
        stretch_req = 1'b1;
        n = 0;
        do
        begin
            step;
            stretch_req = 1'b0;
            n++;
        end
        while (stretch_release !== 1'b1 && n < 300);
        bound(n, 300);
        chk(n[7:0], exp);
    endtask
    // Measures one low and one high phase of the master SCL, then stops it
    task automatic master(input logic lf, input logic [7:0] lo, input logic [7:0] hi);
        low_freq_mode = lf;
        master_en = 1'b1;
        for (n = 0; scl_oe !== 1'b1 && n < 20; n++)
            step;
        bound(n, 20);
        for (n = 0; scl_oe === 1'b1 && n < 300; n++)
            step;
        bound(n, 300);
        chk(n[7:0], lo);
        for (n = 0; scl_oe !== 1'b1 && n < 300; n++)
            step;
        bound(n, 300);
        chk(n[7:0], hi);
        master_en = 1'b0;
        for (n = 0; scl_oe === 1'b1 && n < 300; n++)
            step;
        bound(n, 300);
        repeat (hi + 3) step;
        chk({6'h00, scl_oe, scl_out}, 8'h00);
    endtask
    task automatic au(input logic [7:0] c, input logic r, input ccr_i2s_mode_type m,
                      input logic e);
        wr(8'h1A, c);
        repeater_mode = r;
        detect_valid = r;
        detect_mode = m;
        step;
        chk({7'h00, surround_en}, {7'h00, e});
        chk({7'h00, data_island_en}, {7'h00, e});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rd_chk(8'h17, 8'h1E);
        rd_chk(8'h18, 8'hA1);
        rd_chk(8'h19, 8'hA5);
        rd_chk(8'h1A, 8'h00);
        rd_chk(8'h1B, 8'h00);
        wr(8'h1A, 8'hFF);
        rd_chk(8'h1A, 8'h81);
        wr(8'h1B, 8'h55);
        rd_chk(8'h1B, 8'h00);
        wr(8'h2A, 8'h77);
        rd_chk(8'h2A, 8'h00);
        $display("finished register access");
    endtask
    task automatic t_fwd;
        fw(7'h2C, 1'b1);
        fw(7'h50, 1'b1);
        fw(7'h33, 1'b0);
        wr(8'h17, 8'h9E);
        fw(7'h33, 1'b1);
        fw(7'h12, 1'b0);
        fw(7'h2C, 1'b1);
        wr(8'h17, 8'h1E);
        $display("finished forwarding");
    endtask
    task automatic t_timing;
        stretch(8'd67);
        wr(8'h18, 8'h0A);
        wr(8'h19, 8'h0F);
        stretch(8'd7);
        master(1'b0, 8'd6, 8'd4);
        master(1'b1, 8'd16, 8'd11);
        $display("finished SCL timing");
    endtask
    // Nine SCL periods must pass the filter; SDA falls 200 ns after SCL, so it
    // trails by 2 cycles plus the hold delay
    task automatic frame(input logic [7:0] gap);
        int falls, t_scl, t_sda;
        logic prev;
        falls = 0;
        t_scl = -1;
        t_sda = -1;
        prev = scl_filt;
        go = 1'b1;
        for (n = 0; n < 90; n++)
        begin
            step;
            go = 1'b0;
            if (prev === 1'b1 && scl_filt === 1'b0)
            begin
                falls++;
                if (t_scl < 0)
                begin
                    t_scl = n;
                end
            end
            if (sda_held === 1'b0 && t_sda < 0)
            begin
                t_sda = n;
            end
            prev = scl_filt;
        end
        chk(falls[7:0], 8'd9);
        chk(8'(t_sda - t_scl), gap);
        chk({7'h00, sda_held}, 8'h01);
    endtask
    // A 100 ns pulse is narrower than the filter accepts
    task automatic t_filter;
        frame(8'd3);
        wr(8'h17, 8'h7E);
        frame(8'd5);
        wr(8'h17, 8'h1E);
        glitch = 1'b1;
        for (n = 0; n < 10; n++)
        begin
            step;
            glitch = 1'b0;
            chk({7'h00, scl_filt}, 8'h01);
        end
        $display("finished pin filter");
    endtask
    task automatic t_bist;
        bist_active = 1'b1;
        crc_err = 1'b1;
        repeat (260) step;
        crc_err = 1'b0;
        step;
        rd_chk(8'h1B, 8'hFF);
        crc_clear_cmd = 1'b1;
        crc_err = 1'b1;
        step;
        crc_clear_cmd = 1'b0;
        repeat (3) step;
        crc_err = 1'b0;
        step;
        rd_chk(8'h1B, 8'h03);
        bist_start = 1'b1;
        step;
        bist_start = 1'b0;
        bist_active = 1'b0;
        crc_err = 1'b1;
        step;
        crc_err = 1'b0;
        step;
        rd_chk(8'h1B, 8'h00);
        $display("finished error counter");
    endtask
    task automatic t_audio;
        au(8'h01, 1'b0, I2S_2CH, 1'b1);
        au(8'h00, 1'b0, I2S_SURROUND, 1'b0);
        au(8'h01, 1'b1, I2S_2CH, 1'b0);
        au(8'h00, 1'b1, I2S_SURROUND, 1'b1);
        au(8'h81, 1'b1, I2S_4CH, 1'b1);
        au(8'h80, 1'b1, I2S_SURROUND, 1'b0);
        $display("finished audio path");
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        #10;
        rstn = 1'b1;
        step;
        t_regs;
        t_fwd;
        t_timing;
        t_filter;
        t_bist;
        t_audio;
        close_out;
    end
endmodule

// file: src/ccr_pkg.sv
// Constants, register map and carrier types for the control-channel config registers.
// Assumes one 10 MHz system clock; I2C pins arrive asynchronously.
package ccr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_I2C_CTRL = 8'h17;
    localparam logic [7:0] ADDR_SCL_HIGH = 8'h18;
    localparam logic [7:0] ADDR_SCL_LOW = 8'h19;
    localparam logic [7:0] ADDR_AUDIO_CTRL = 8'h1A;
    localparam logic [7:0] ADDR_CRC_ERR = 8'h1B;
    localparam logic [7:0] RST_I2C_CTRL = 8'h1E;
    localparam logic [7:0] RST_SCL_HIGH = 8'hA1;
    localparam logic [7:0] RST_SCL_LOW = 8'hA5;
    localparam logic [7:0] RST_AUDIO_CTRL = 8'h00;
    localparam logic [7:0] AUDIO_CTRL_MASK = 8'h81;
    localparam logic [7:0] CRC_ERR_MAX = 8'hFF;
    localparam int PASS_ALL_BIT = 7;
    localparam int HOLD_MSB = 6;
    localparam int HOLD_LSB = 4;
    localparam int FILT_MSB = 3;
    localparam int FILT_LSB = 0;
    localparam int AUTO_BLOCK_BIT = 7;
    localparam int SURROUND_BIT = 0;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 100000;
    localparam int HOLD_UNIT_PS = 40000;
    localparam int FILT_UNIT_PS = 5000;
    localparam int OSC_UNIT_PS = 40000;
    localparam int OSC_NOM_KHZ = 33000;
    localparam int OSC_LF_KHZ = 12500;
    localparam int OSC_LF_UNIT_PS = OSC_UNIT_PS * OSC_NOM_KHZ / OSC_LF_KHZ;
    localparam int CNT_W = 12;
    localparam int HOLD_DEPTH = 4;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        I2S_2CH,
        I2S_4CH,
        I2S_SURROUND
    } ccr_i2s_mode_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_reg_req_type;

    typedef struct packed {
        logic valid;
        logic [6:0] target;
    } ccr_id_req_type;

    // Round up to whole cycles, never below one
    function automatic logic [CNT_W-1:0] units_to_cycles(input int units, input int unit_ps);
        int c;
        c = (units * unit_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1)
        begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction
endpackage

// file: src/ccr_regs.sv
// Control-channel forwarding, I2C timing, audio and BIST count registers.
// Assumes a register port from the local serial control slave on the same clock.
`timescale 1ns/1ns
module ccr_regs (
    input wire logic clock,
    input wire logic rstn,
    input ccr_pkg::ccr_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input ccr_pkg::ccr_id_req_type id_req,
    input wire logic [6:0] local_id,
    input wire logic [6:0] remote_des_id,
    input wire logic [6:0] remote_slave_id,
    output logic forward_valid,
    output logic forward_bidir_control_channel,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_filt,
    output logic sda_held,
    input wire logic low_freq_mode,
    input wire logic master_en,
    output logic scl_out,
    output logic scl_oe,
    input wire logic stretch_req,
    output logic stretch_release,
    input wire logic repeater_mode,
    input wire logic detect_valid,
    input ccr_pkg::ccr_i2s_mode_type detect_mode,
    output logic surround_en,
    output logic data_island_en,
    input wire logic bist_start,
    input wire logic bist_active,
    input wire logic crc_err,
    input wire logic crc_clear_cmd
);
    import ccr_pkg::*;

    typedef enum {M_IDLE, M_HIGH, M_LOW} ccr_mstate_type;

    // ==========================================================
    // Register file
    logic [7:0] i2c_ctrl_q, i2c_ctrl_d, scl_high_q, scl_high_d, scl_low_q, scl_low_d;
    logic [7:0] audio_q, audio_d, crc_cnt_q, crc_cnt_d, rdata_d;

    always_comb
    begin
        i2c_ctrl_d = i2c_ctrl_q;
        scl_high_d = scl_high_q;
        scl_low_d = scl_low_q;
        audio_d = audio_q;
        crc_cnt_d = crc_cnt_q;
        rdata_d = reg_rdata;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                ADDR_I2C_CTRL: i2c_ctrl_d = reg_req.wdata;
                ADDR_SCL_HIGH: scl_high_d = reg_req.wdata;
                ADDR_SCL_LOW: scl_low_d = reg_req.wdata;
                ADDR_AUDIO_CTRL: audio_d = reg_req.wdata & AUDIO_CTRL_MASK;
                default: ;
            endcase
        end
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                ADDR_I2C_CTRL: rdata_d = i2c_ctrl_q;
                ADDR_SCL_HIGH: rdata_d = scl_high_q;
                ADDR_SCL_LOW: rdata_d = scl_low_q;
                ADDR_AUDIO_CTRL: rdata_d = audio_q;
                ADDR_CRC_ERR: rdata_d = crc_cnt_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // Start or clear beats an error in the same cycle: a new run begins empty
        if (bist_start || crc_clear_cmd)
        begin
            crc_cnt_d = 8'h00;
        end
        else if (bist_active && crc_err && crc_cnt_q != CRC_ERR_MAX)
        begin
            crc_cnt_d = crc_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            i2c_ctrl_q <= RST_I2C_CTRL;
            scl_high_q <= RST_SCL_HIGH;
            scl_low_q <= RST_SCL_LOW;
            audio_q <= RST_AUDIO_CTRL;
            crc_cnt_q <= 8'h00;
            reg_rdata <= 8'h00;
        end
        else
        begin
            i2c_ctrl_q <= i2c_ctrl_d;
            scl_high_q <= scl_high_d;
            scl_low_q <= scl_low_d;
            audio_q <= audio_d;
            crc_cnt_q <= crc_cnt_d;
            reg_rdata <= rdata_d;
        end
    end

    // ==========================================================
    // Forwarding decision
    logic fwd_d, fwd_v_d, fwd_q, fwd_v_q;

    always_comb
    begin
        fwd_v_d = id_req.valid;
        fwd_d = 1'b0;
        if (id_req.valid)
        begin
            if (i2c_ctrl_q[PASS_ALL_BIT])
            begin
                fwd_d = id_req.target != local_id;
            end
            else
            begin
                fwd_d = id_req.target == remote_des_id
                    || id_req.target == remote_slave_id;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fwd_q <= 1'b0;
            fwd_v_q <= 1'b0;
        end
        else
        begin
            fwd_q <= fwd_d;
            fwd_v_q <= fwd_v_d;
        end
    end

    assign forward_valid = fwd_v_q;
    assign forward_bidir_control_channel = fwd_q;

    // ==========================================================
    // Pin synchronisers, glitch filter and SDA hold
    // At 100 ns per cycle any filter depth spans one cycle; the limit is the clock rate
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;
    logic [CNT_W-1:0] scl_cnt_q, scl_cnt_d, sda_cnt_q, sda_cnt_d, filt_cyc, hold_cyc;
    logic [HOLD_DEPTH-1:0] sda_dly_q, sda_dly_d;

    always_comb
    begin
        filt_cyc = units_to_cycles(int'(i2c_ctrl_q[FILT_MSB:FILT_LSB]), FILT_UNIT_PS);
        hold_cyc = units_to_cycles(int'(i2c_ctrl_q[HOLD_MSB:HOLD_LSB]), HOLD_UNIT_PS);
        scl_f_d = scl_f_q;
        sda_f_d = sda_f_q;
        scl_cnt_d = '0;
        sda_cnt_d = '0;
        if (scl_s_q[1] != scl_f_q)
        begin
            scl_cnt_d = scl_cnt_q + 1'b1;
            if (scl_cnt_q >= filt_cyc)
            begin
                scl_f_d = scl_s_q[1];
                scl_cnt_d = '0;
            end
        end
        if (sda_s_q[1] != sda_f_q)
        begin
            sda_cnt_d = sda_cnt_q + 1'b1;
            if (sda_cnt_q >= filt_cyc)
            begin
                sda_f_d = sda_s_q[1];
                sda_cnt_d = '0;
            end
        end
        sda_dly_d = {sda_dly_q[HOLD_DEPTH-2:0], sda_f_q};
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_cnt_q <= '0;
            sda_cnt_q <= '0;
            sda_dly_q <= '1;
        end
        else
        begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_f_q <= scl_f_d;
            sda_f_q <= sda_f_d;
            scl_cnt_q <= scl_cnt_d;
            sda_cnt_q <= sda_cnt_d;
            sda_dly_q <= sda_dly_d;
        end
    end

    assign scl_filt = scl_f_q;
    assign sda_held = sda_dly_q[hold_cyc[1:0] - 2'h1];

    // ==========================================================
    // Master SCL generator and slave setup timer
    ccr_mstate_type mst_q, mst_d;
    logic [CNT_W-1:0] mcnt_q, mcnt_d, high_cyc, low_cyc, scnt_q, scnt_d;
    logic sbusy_q, sbusy_d, srel_q, srel_d;
    int unit_ps;

    always_comb
    begin
        unit_ps = low_freq_mode ? OSC_LF_UNIT_PS : OSC_UNIT_PS;
        high_cyc = units_to_cycles(int'(scl_high_q), unit_ps);
        low_cyc = units_to_cycles(int'(scl_low_q), unit_ps);
        mst_d = mst_q;
        mcnt_d = mcnt_q + 1'b1;
        unique case (mst_q)
            M_IDLE:
            begin
                mcnt_d = '0;
                if (master_en)
                begin
                    mst_d = M_LOW;
                end
            end
            M_LOW:
            begin
                if (mcnt_q + 1'b1 >= low_cyc)
                begin
                    mst_d = M_HIGH;
                    mcnt_d = '0;
                end
            end
            M_HIGH:
            begin
                if (mcnt_q + 1'b1 >= high_cyc)
                begin
                    mst_d = master_en ? M_LOW : M_IDLE;
                    mcnt_d = '0;
                end
            end
        endcase
        sbusy_d = sbusy_q;
        scnt_d = '0;
        srel_d = 1'b0;
        if (!sbusy_q && stretch_req)
        begin
            sbusy_d = 1'b1;
        end
        else if (sbusy_q)
        begin
            scnt_d = scnt_q + 1'b1;
            if (scnt_q + 1'b1 >= low_cyc)
            begin
                sbusy_d = 1'b0;
                srel_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mst_q <= M_IDLE;
            mcnt_q <= '0;
            scnt_q <= '0;
            sbusy_q <= 1'b0;
            srel_q <= 1'b0;
        end
        else
        begin
            mst_q <= mst_d;
            mcnt_q <= mcnt_d;
            scnt_q <= scnt_d;
            sbusy_q <= sbusy_d;
            srel_q <= srel_d;
        end
    end

    // Open-drain: drive low only, release for high
    assign scl_out = 1'b0;
    assign scl_oe = mst_q == M_LOW;
    assign stretch_release = srel_q;

    // ==========================================================
    // Audio transport
    // Detection wins over the software bit only in repeaters with detection unblocked
    logic det_active;

    always_comb
    begin
        det_active = repeater_mode && !audio_q[AUTO_BLOCK_BIT] && detect_valid;
        surround_en = det_active ? detect_mode == I2S_SURROUND
            : audio_q[SURROUND_BIT];
        data_island_en = surround_en;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_CRC_SAT: assert property (crc_cnt_q == CRC_ERR_MAX && !bist_start && !crc_clear_cmd
        |=> crc_cnt_q == CRC_ERR_MAX) else $error("crc counter wrapped");
    AST_CRC_INC: assert property (bist_active && crc_err && !bist_start && !crc_clear_cmd
        && crc_cnt_q < CRC_ERR_MAX |=> crc_cnt_q == $past(crc_cnt_q) + 8'h01)
        else $error("crc counter missed an error");
    AST_CRC_CLR: assert property (bist_start || crc_clear_cmd |=> crc_cnt_q == 8'h00)
        else $error("crc counter not cleared");
    AST_FWD_MATCH: assert property (id_req.valid && !i2c_ctrl_q[PASS_ALL_BIT]
        && id_req.target == remote_des_id |=> forward_bidir_control_channel)
        else $error("remote id not forwarded");
    AST_FWD_LOCAL: assert property (id_req.valid && i2c_ctrl_q[PASS_ALL_BIT]
        && id_req.target == local_id |=> !forward_bidir_control_channel)
        else $error("local id forwarded");
    AST_AUDIO_RSV: assert property ((audio_q & ~AUDIO_CTRL_MASK) == 8'h00)
        else $error("reserved audio bits set");
    AST_SURR_SW: assert property (!repeater_mode |-> surround_en == audio_q[SURROUND_BIT])
        else $error("surround not from register");
    AST_ISLAND: assert property (surround_en |-> data_island_en)
        else $error("surround without data island");
    AST_BLOCK: assert property (audio_q[AUTO_BLOCK_BIT] |-> surround_en == audio_q[SURROUND_BIT])
        else $error("detection not blocked");
    AST_STRETCH: assert property (sbusy_q && scnt_q + 1'b1 >= low_cyc |=> stretch_release)
        else $error("stretch not released");
    AST_LOW_LEN: assert property (mst_q == M_LOW && mcnt_q + 1'b1 < low_cyc |=> mst_q == M_LOW)
        else $error("scl low too short");

    COV_FWD: cover property (forward_valid && forward_bidir_control_channel);
    COV_SAT: cover property (crc_cnt_q == CRC_ERR_MAX);
    COV_MASTER: cover property (mst_q == M_HIGH ##1 mst_q == M_LOW);
    COV_OVR: cover property (det_active && surround_en != audio_q[SURROUND_BIT]);
endmodule
